/* File: logic/oag_top.sv */
`timescale 1ns/1ps
// Operation
// - working field goes below bank pointer upper nibble; pointer at register 253
// - full register addresses valid at 0-127 and 240-255
// - register pair is even address in 0..126 or 240..254, 16-bit value
// - working pair is even 0..14; odd member as pair is an error
// - indirect uses register or pair contents as address
// - indexed load adds working register contents to instruction address
// - direct address decoded only for jump and call
// - relative branch adds signed offset to next instruction address
// - relative jump and decrement branch are two bytes, relative only
// - upper nibble E maps field onto working register
// - decrement branch taken only when decremented value nonzero
// - status flags live in register 252, addressable normally
module oag_top (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire oag_pkg::oag_req_t REQ,
   input wire logic [7:0] RF_DATA_A,
   input wire logic [7:0] RF_DATA_B,
   input wire logic WR_EN,
   input wire logic [7:0] WR_ADDR,
   input wire logic [7:0] WR_DATA,
   output logic [7:0] RF_ADDR_A,
   output logic [7:0] RF_ADDR_B,
   output logic [7:0] BANK_PTR,
   output logic [7:0] FLAGS_OUT,
   output logic RES_VALID,
   output oag_pkg::oag_res_t RES
);
   logic [7:0] bank_reg;
   logic [7:0] flag_reg;
   logic valid_reg;
   oag_pkg::oag_res_t res_reg;
   oag_pkg::oag_res_t res_next;

   wire logic short_form;
   wire logic [7:0] exp_addr;
   wire logic exp_valid;
   wire logic [7:0] idx_addr;
   wire logic idx_valid;
   wire logic pair_ok;
   wire logic wpair_ok;
   wire logic [15:0] rel_dest;
   wire logic [7:0] dec_val;
   wire logic [7:0] index_sum;
   wire logic [15:0] pair_word;
   wire logic [7:0] cur_bank;
   wire logic m_reg;
   wire logic m_wreg;
   wire logic m_pair;
   wire logic m_wpair;
   wire logic m_ind;
   wire logic m_ind_pair;
   wire logic m_index;
   wire logic m_direct;
   wire logic m_rel;
   wire logic m_decrement_and_branch;
   wire logic m_imm;
   wire logic m_known;
   wire logic m_byte_reg;
   wire logic [15:0] reg_word;
   wire logic [15:0] ind_word;
   wire logic [15:0] idx_word;
   wire logic [15:0] seq_dest;
   wire logic decrement_and_branch_take;
   wire logic [15:0] decrement_and_branch_dest;
   wire logic reg_err;
   wire logic pair_err;
   wire logic wpair_err;
   wire logic ind_err;
   wire logic ind_pair_err;
   wire logic index_err;
   wire logic direct_err;
   wire logic [15:0] sel_addr;
   wire logic [7:0] sel_data;
   wire logic sel_is_reg;
   wire logic sel_is_mem;
   wire logic sel_take;
   wire logic sel_err;

   // a pointer write in the same cycle is seen at once
   assign cur_bank = (WR_EN && WR_ADDR == oag_pkg::BANK_ADDR) ? WR_DATA : bank_reg;
   assign short_form = REQ.mode == oag_pkg::OAG_WREG || REQ.mode == oag_pkg::OAG_WPAIR
      || REQ.mode == oag_pkg::OAG_DECREMENT_AND_BRANCH;

   oag_reg_expand u_exp (
      .field(REQ.field),
      .bank(cur_bank),
      .short_form(short_form),
      .addr(exp_addr),
      .valid(exp_valid)
   );

   oag_reg_expand u_idx (
      .field(REQ.aux),
      .bank(cur_bank),
      .short_form(1'b1),
      .addr(idx_addr),
      .valid(idx_valid)
   );

   oag_pair_check u_pair (
      .addr(exp_addr),
      .addr_valid(exp_valid),
      .ok(pair_ok)
   );

   assign wpair_ok = !REQ.field[0] && REQ.field[7:4] == 4'h0;

   assign RF_ADDR_A = exp_addr;
   assign RF_ADDR_B = (REQ.mode == oag_pkg::OAG_INDEX) ? idx_addr : exp_addr + 8'h01;

   assign pair_word = {RF_DATA_A, RF_DATA_B};
   assign index_sum = REQ.field + RF_DATA_B;
   assign rel_dest = REQ.pc + oag_pkg::INSN_LEN + {{8{REQ.aux[7]}}, REQ.aux};
   assign dec_val = RF_DATA_A - 8'h01;

   // one-hot view of the requested mode
   assign m_reg = REQ.mode == oag_pkg::OAG_REG;
   assign m_wreg = REQ.mode == oag_pkg::OAG_WREG;
   assign m_pair = REQ.mode == oag_pkg::OAG_PAIR;
   assign m_wpair = REQ.mode == oag_pkg::OAG_WPAIR;
   assign m_ind = REQ.mode == oag_pkg::OAG_IND;
   assign m_ind_pair = REQ.mode == oag_pkg::OAG_IND_PAIR;
   assign m_index = REQ.mode == oag_pkg::OAG_INDEX;
   assign m_direct = REQ.mode == oag_pkg::OAG_DIRECT;
   assign m_rel = REQ.mode == oag_pkg::OAG_REL;
   assign m_decrement_and_branch = REQ.mode == oag_pkg::OAG_DECREMENT_AND_BRANCH;
   assign m_imm = REQ.mode == oag_pkg::OAG_IMM;
   assign m_known = m_reg || m_wreg || m_pair || m_wpair || m_ind || m_ind_pair
      || m_index || m_direct || m_rel || m_decrement_and_branch || m_imm;
   assign m_byte_reg = m_reg || m_wreg || m_pair || m_wpair;

   assign reg_word = {oag_pkg::BYTE_ZERO, exp_addr};
   assign ind_word = {oag_pkg::BYTE_ZERO, RF_DATA_A};
   assign idx_word = {oag_pkg::BYTE_ZERO, index_sum};
   assign seq_dest = REQ.pc + oag_pkg::INSN_LEN;
   assign decrement_and_branch_take = dec_val != oag_pkg::BYTE_ZERO;
   assign decrement_and_branch_dest = decrement_and_branch_take ? rel_dest : seq_dest;

   assign reg_err = !exp_valid;
   assign pair_err = !pair_ok;
   assign wpair_err = !wpair_ok;
   assign ind_err = !exp_valid;
   assign ind_pair_err = !pair_ok;
   assign index_err = !REQ.is_load;
   assign direct_err = !REQ.is_jump;

   assign sel_addr = m_byte_reg ? reg_word
      : m_ind ? ind_word
      : m_ind_pair ? pair_word
      : m_index ? idx_word
      : m_direct ? REQ.word
      : m_rel ? rel_dest
      : m_decrement_and_branch ? decrement_and_branch_dest
      : oag_pkg::WORD_ZERO;
   // immediates pass through; range is enforced where they are formed
   assign sel_data = m_imm ? REQ.field
      : m_decrement_and_branch ? dec_val
      : oag_pkg::BYTE_ZERO;
   assign sel_is_reg = m_byte_reg || m_ind || m_index;
   assign sel_is_mem = m_ind_pair || m_direct || m_rel || m_decrement_and_branch;
   assign sel_take = (m_direct && REQ.is_jump) || m_rel || (m_decrement_and_branch && decrement_and_branch_take);
   assign sel_err = (m_reg || m_wreg) ? reg_err
      : m_pair ? pair_err
      : m_wpair ? wpair_err
      : m_ind ? ind_err
      : m_ind_pair ? ind_pair_err
      : m_index ? index_err
      : m_direct ? direct_err
      : !m_known;

   always_comb begin
      res_next.addr = sel_addr;
      res_next.data = sel_data;
      res_next.is_reg = sel_is_reg;
      res_next.is_mem = sel_is_mem;
      res_next.take = sel_take;
      res_next.err = sel_err;
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         bank_reg <= oag_pkg::BYTE_ZERO;
      end else if (WR_EN && WR_ADDR == oag_pkg::BANK_ADDR) begin
         bank_reg <= WR_DATA;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         flag_reg <= oag_pkg::BYTE_ZERO;
      end else if (WR_EN && WR_ADDR == oag_pkg::FLAG_ADDR) begin
         flag_reg <= WR_DATA;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         valid_reg <= 1'b0;
         res_reg <= '0;
      end else begin
         valid_reg <= REQ_VALID;
         if (REQ_VALID) begin
            res_reg <= res_next;
         end
      end
   end

   assign BANK_PTR = bank_reg;
   assign FLAGS_OUT = flag_reg;
   assign RES_VALID = valid_reg;
   assign RES = res_reg;
endmodule

/* File: logic/oag_pkg.sv */
package oag_pkg;
   localparam logic [7:0] FLAG_ADDR = 8'hfc;
   localparam logic [7:0] BANK_ADDR = 8'hfd;
   localparam logic [7:0] LOW_TOP = 8'h7f;
   localparam logic [7:0] HIGH_BASE = 8'hf0;
   localparam logic [3:0] ESC_NIBBLE = 4'he;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [15:0] INSN_LEN = 16'h0002;

   typedef enum logic [3:0] {
      OAG_REG, OAG_WREG, OAG_PAIR, OAG_WPAIR, OAG_IND, OAG_IND_PAIR,
      OAG_INDEX, OAG_DIRECT, OAG_REL, OAG_DECREMENT_AND_BRANCH, OAG_IMM
   } oag_mode_t;

   typedef struct packed {
      oag_mode_t mode;
      logic [7:0] field;
      logic [7:0] aux;
      logic [15:0] word;
      logic [15:0] pc;
      logic is_load;
      logic is_jump;
   } oag_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
      logic is_reg;
      logic is_mem;
      logic take;
      logic err;
   } oag_res_t;
endpackage

/* File: logic/oag_reg_expand.sv */
`timescale 1ns/1ps
module oag_reg_expand (
   input wire logic [7:0] field,
   input wire logic [7:0] bank,
   input wire logic short_form,
   output logic [7:0] addr,
   output logic valid
);
   wire logic esc;
   wire logic [7:0] wide;
   assign esc = field[7:4] == oag_pkg::ESC_NIBBLE;
   assign wide = {bank[7:4], field[3:0]};
   assign addr = (short_form || esc) ? wide : field;
   assign valid = (addr <= oag_pkg::LOW_TOP) || (addr >= oag_pkg::HIGH_BASE);
endmodule

/* File: logic/oag_pair_check.sv */
`timescale 1ns/1ps
module oag_pair_check (
   input wire logic [7:0] addr,
   input wire logic addr_valid,
   output logic ok
);
   assign ok = addr_valid && !addr[0];
endmodule

/* File: tb/oag_top_sva.sv */
`timescale 1ns/1ps
module oag_top_sva (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   input wire oag_pkg::oag_req_t REQ,
   input wire logic [7:0] RF_DATA_A,
   input wire logic WR_EN,
   input wire logic [7:0] WR_ADDR,
   input wire logic [7:0] WR_DATA,
   input wire logic [7:0] RF_ADDR_A,
   input wire logic [7:0] BANK_PTR,
   input wire logic RES_VALID,
   input wire oag_pkg::oag_res_t RES
);
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   wire q = REQ_VALID;
   wire [3:0] m = REQ.mode;
   wire [7:0] f = REQ.field;
   wire [7:0] w = {BANK_PTR[7:4], f[3:0]};
   wire [15:0] rel = REQ.pc + 16'h0002 + {{8{REQ.aux[7]}}, REQ.aux};
   wire bad = f > 8'h7f && f < 8'hf0;
   chk_res_pulse: assert property (q |=> RES_VALID) else $error("no strobe");
   chk_wreg_expand: assert property (m == oag_pkg::OAG_WREG && !WR_EN |-> RF_ADDR_A == w)
      else $error("bad working address");
   chk_esc_nibble: assert property (m == oag_pkg::OAG_REG && f[7:4] == 4'he && !WR_EN
      |-> RF_ADDR_A == w) else $error("bad escape address");
   chk_reg_range: assert property (q && m == oag_pkg::OAG_REG && f[7:4] != 4'he
      |=> RES.err == $past(bad)) else $error("bad range check");
   chk_rel_target: assert property (q && m == oag_pkg::OAG_REL
      |=> RES.addr == $past(rel)) else $error("bad relative target");
   chk_decrement_and_branch_count: assert property (q && m == oag_pkg::OAG_DECREMENT_AND_BRANCH |=>
      RES.data == $past(RF_DATA_A) - 8'h01 && RES.take == (RES.data != 8'h00))
      else $error("bad decrement branch");
   chk_direct_dest: assert property (q && m == oag_pkg::OAG_DIRECT && REQ.is_jump
      |=> RES.addr == $past(REQ.word) && !RES.err) else $error("bad jump target");
   chk_bank_load: assert property (WR_EN && WR_ADDR == oag_pkg::BANK_ADDR
      |=> BANK_PTR == $past(WR_DATA)) else $error("pointer not loaded");
   chk_bank_bypass: assert property (m == oag_pkg::OAG_WREG && WR_EN
      && WR_ADDR == oag_pkg::BANK_ADDR |-> RF_ADDR_A == {WR_DATA[7:4], f[3:0]})
      else $error("pointer bypass missing");
   chk_imm_pass: assert property (q && m == oag_pkg::OAG_IMM
      |=> RES.data == $past(f) && !RES.err) else $error("bad immediate");
   cover property (q && m == oag_pkg::OAG_DECREMENT_AND_BRANCH);
   cover property (q && m == oag_pkg::OAG_IMM);
   cover property (q && m == oag_pkg::OAG_INDEX);
   cover property (q && m == oag_pkg::OAG_IND_PAIR);
endmodule

/* File: tb/oag_top_tb_top.sv */
`timescale 1ns/1ps
module oag_top_tb_top;
   logic clk = 0, rst = 1, vld = 0, wen = 0, rv;
   logic [7:0] wa = 8'h00, wd = 8'h00, ra, rb, bp, fl;
   oag_pkg::oag_req_t req = '0;
   oag_pkg::oag_res_t res;
   int n_errors = 0, num_checks = 0, cyc = 0;
   // register file model: data is a fixed function of the address
   oag_top uut (.SYS_CLK(clk), .RST(rst), .REQ_VALID(vld), .REQ(req),
      .RF_DATA_A(ra ^ 8'h5a), .RF_DATA_B(rb + 8'h11), .WR_EN(wen), .WR_ADDR(wa),
      .WR_DATA(wd), .RF_ADDR_A(ra), .RF_ADDR_B(rb), .BANK_PTR(bp), .FLAGS_OUT(fl),
      .RES_VALID(rv), .RES(res));
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 300) begin
         n_errors++;
         close_out();
      end
   end
   task automatic close_out();
      if (n_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      vld = 0;
      wen = 1;
      wa = a;
      wd = d;
      @(negedge clk);
      wen = 0;
      @(negedge clk);
   endtask
   // requests stay back to back until wr or the end of the test lowers vld
   task automatic go(input oag_pkg::oag_mode_t m, input logic [7:0] f, input logic [7:0] x,
      input logic [15:0] ea, input logic ee);
      req.mode = m;
      req.field = f;
      req.aux = x;
      vld = 1;
      @(negedge clk);
      ck({14'h0000, rv, res.err}, {14'h0000, 1'b1, ee});
      if (!ee) begin
         ck(res.addr, ea);
      end
   endtask
   initial begin
      req.pc = 16'h0100;
      req.word = 16'h1234;
      req.is_load = 1'b1;
      req.is_jump = 1'b1;
      repeat (3) @(negedge clk);
      rst = 0;
      ck({bp, fl}, 16'h0000);
      wr(8'hfc, 8'h3c);
      ck({8'h00, fl}, 16'h003c);
      wr(8'hfd, 8'h70);
      ck({8'h00, bp}, 16'h0070);
      go(oag_pkg::OAG_WREG, 8'h05, 8'h00, 16'h0075, 1'b0);
      go(oag_pkg::OAG_REG, 8'he3, 8'h00, 16'h0073, 1'b0);
      go(oag_pkg::OAG_REG, 8'h80, 8'h00, 16'h0000, 1'b1);
      go(oag_pkg::OAG_PAIR, 8'h7f, 8'h00, 16'h0000, 1'b1);
      go(oag_pkg::OAG_WPAIR, 8'h0f, 8'h00, 16'h0000, 1'b1);
      go(oag_pkg::OAG_IND_PAIR, 8'h20, 8'h00, 16'h7a32, 1'b0);
      ck({14'h0000, res.is_reg, res.is_mem}, 16'h0001);
      wr(8'hfd, 8'h20);
      go(oag_pkg::OAG_INDEX, 8'h40, 8'h03, 16'h0074, 1'b0);
      ck({rb, ra}, 16'h2340);
      go(oag_pkg::OAG_DIRECT, 8'h00, 8'h00, 16'h1234, 1'b0);
      ck({14'h0000, res.is_mem, res.take}, 16'h0003);
      go(oag_pkg::OAG_REL, 8'h00, 8'h80, 16'h0082, 1'b0);
      ck({14'h0000, res.is_mem, res.take}, 16'h0003);
      wr(8'hfd, 8'h50);
      go(oag_pkg::OAG_DECREMENT_AND_BRANCH, 8'h0b, 8'h10, 16'h0102, 1'b0);
      ck({res.data, 7'h00, res.take}, 16'h0000);
      go(oag_pkg::OAG_DECREMENT_AND_BRANCH, 8'h0c, 8'hfe, 16'h0100, 1'b0);
      ck({res.data, 7'h00, res.take}, 16'h0501);
      go(oag_pkg::OAG_IND, 8'h10, 8'h00, 16'h004a, 1'b0);
      ck({14'h0000, res.is_reg, res.is_mem}, 16'h0002);
      go(oag_pkg::OAG_REG, 8'hfc, 8'h00, 16'h00fc, 1'b0);
      go(oag_pkg::OAG_REG, 8'hf5, 8'h00, 16'h00f5, 1'b0);
      go(oag_pkg::OAG_IMM, 8'h12, 8'h00, 16'h0000, 1'b0);
      ck({8'h00, res.data}, 16'h0012);
      go(oag_pkg::OAG_IMM, 8'h80, 8'h00, 16'h0000, 1'b0);
      ck({8'h00, res.data}, 16'h0080);
      wen = 1;
      wa = 8'hfd;
      wd = 8'h30;
      go(oag_pkg::OAG_WREG, 8'h02, 8'h00, 16'h0032, 1'b0);
      wen = 0;
      ck({8'h00, bp}, 16'h0030);
      vld = 0;
      @(negedge clk);
      close_out();
   end
endmodule
bind oag_top oag_top_sva chk (.SYS_CLK(SYS_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
   .REQ(REQ), .RF_DATA_A(RF_DATA_A), .WR_EN(WR_EN), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA),
   .RF_ADDR_A(RF_ADDR_A), .BANK_PTR(BANK_PTR), .RES_VALID(RES_VALID), .RES(RES));
